// ### hw/spk_host_pkg.sv
/*
  Package for the host side of the shared speaker and bus duty logic:
  timing constants, phase codes and the pin carrier type.
  Assumes a 40 MHz core clock and a bus clock near 200 ns period.
*/
package spk_host_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 25;               // Core clock period
  localparam int BUS_CLK_NS = 200;          // Bus clock period
  localparam int ALE_HOLD_MIN_NS = BUS_CLK_NS / 2;   // Half a bus clock
  localparam int ALE_HOLD_MAX_NS = BUS_CLK_NS;       // One bus clock
  // Least time rounds up
  localparam int ALE_HOLD_CYC_I = (ALE_HOLD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] ALE_HOLD_CYC = ALE_HOLD_CYC_I[3:0];

  // ****************************************
  // Synchroniser lanes
  // ****************************************
  localparam int SYNC_W = 3;                // Number of pin lanes
  localparam int LANE_BCLK = 0;             // Bus clock lane
  localparam int LANE_SPK = 1;              // Speaker line lane
  localparam int LANE_SEL = 2;              // Select/backoff lane

  // ****************************************
  // Phases and reset values
  // ****************************************
  localparam logic [1:0] PHASE_0 = 2'h0;
  localparam logic [1:0] PHASE_1 = 2'h1;
  localparam logic [1:0] PHASE_2 = 2'h2;
  localparam logic [1:0] PHASE_3 = 2'h3;
  localparam logic [7:0] DRQ_NONE = 8'h00;  // All DMA requests off
  localparam logic [2:0] HALT_CNT_RST = 3'h0;

  // Two-way pin drive
  typedef struct packed {
    logic out;                              // Level driven
    logic oe;                               // High while driving
  } pin_drive_type;

endpackage : spk_host_pkg

// ### hw/pin_sync.sv
/*
  Two-flop synchroniser with edge detect for a group of pin inputs.
  Assumes inputs are asynchronous to clock_i; edges are reported in the
  same cycle that the second flop takes a new level.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Pins
  input wire logic [spk_host_pkg::SYNC_W-1:0] pin_i,
  // Synchronised levels and edges
  output logic [spk_host_pkg::SYNC_W-1:0] level_o,
  output logic [spk_host_pkg::SYNC_W-1:0] rise_o,
  output logic [spk_host_pkg::SYNC_W-1:0] fall_o
);
  import spk_host_pkg::*;

  logic [SYNC_W-1:0] meta;    // First stage, read only by stage two
  logic [SYNC_W-1:0] stable;  // Second stage
  logic [SYNC_W-1:0] last;    // Previous stable value

  // ****************************************
  // Sync chain, one lane per pin
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_lane
      always_ff @(posedge clock_i) begin
        if (srst_i) begin
          meta[g] <= 1'b0;
          stable[g] <= 1'b0;
          last[g] <= 1'b0;
        end else begin
          meta[g] <= pin_i[g];
          stable[g] <= meta[g];
          last[g] <= stable[g];
        end
      end
      assign rise_o[g] = stable[g] & ~last[g];
      assign fall_o[g] = ~stable[g] & last[g];
    end
  endgenerate

  assign level_o = stable;

endmodule : pin_sync
`default_nettype wire

// ### hw/spk_host.sv
/*
  Host side of the shared speaker scheme plus host bus duties:
  ALE voltage signalling at reset, data bus idle, DMA request inhibit
  on backoff, backoff grant and clock halt permission.
  Assumes bus clock, speaker and select/backoff arrive as raw pins;
  other inputs come from host logic on clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module spk_host (
  // Clock and reset (reset is the bus reset drive)
  input wire logic clock_i,
  input wire logic srst_i,
  // Raw pins
  input wire logic bus_clock_i,
  input wire logic speaker_line_i,
  input wire logic select_backoff_line_n_i,
  output spk_host_pkg::pin_drive_type speaker_line_o,
  // Address latch enable
  input wire logic bus_5v_i,
  input wire logic ale_req_i,
  output logic ale_o,
  // Data bus drive
  input wire logic cycle_active_i,
  input wire logic sd_drive_i,
  output logic sd_oe_o,
  // DMA requests
  input wire logic [7:0] drq_i,
  output logic [7:0] drq_o,
  input wire logic driveback_done_i,
  // Backoff grant
  input wire logic bus_idle_i,
  output logic backoff_grant_o,
  // Stop clock control
  input wire logic stop_bcast_i,
  input wire logic stop_mode_i,
  input wire logic cmd_active_i,
  input wire logic [2:0] clk_count_i,
  output logic clk_halt_o
);
  import spk_host_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SYNC_W-1:0] pin_level;
  logic [SYNC_W-1:0] pin_rise;
  logic [SYNC_W-1:0] pin_fall;

  // Select lane is carried inverted, so the flops' reset value is the idle level
  pin_sync pin_sync_inst (
    .clock_i(clock_i),
    .srst_i(srst_i),
    .pin_i({~select_backoff_line_n_i, speaker_line_i, bus_clock_i}),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  wire bclk_rise = pin_rise[LANE_BCLK];     // Bus clock rising edge
  wire bclk_fall = pin_fall[LANE_BCLK];     // Bus clock falling edge
  wire bclk_edge = bclk_rise | bclk_fall;   // Any phase boundary
  wire spk_level = pin_level[LANE_SPK];     // Speaker line level
  wire sel_low = pin_level[LANE_SEL];       // Select/backoff asserted

  // ****************************************
  // ALE and bus voltage signalling
  // ****************************************
  logic bus_5v;              // Voltage strap caught during reset
  logic [3:0] hold_cnt;      // Cycles left of post-reset ALE hold
  wire hold_active = (hold_cnt != 4'h0);

  // Strap capture while reset is applied, then hold countdown
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bus_5v <= bus_5v_i;
      hold_cnt <= ALE_HOLD_CYC;
    end else if (hold_active) begin
      hold_cnt <= hold_cnt - 4'h1;
    end
  end

  // Strap level during reset and hold, normal ALE after
  assign ale_o = (srst_i || hold_active) ? (srst_i ? bus_5v_i : bus_5v) : ale_req_i;

  // ****************************************
  // Phase tracking
  // ****************************************
  logic ale_seen;            // First normal ALE observed
  logic synced;              // Phase counter aligned
  logic [1:0] phase;         // Current phase
  wire first_align = ~synced & ale_seen & bclk_rise;

  // Align on first rise after ALE, then advance per bus clock edge
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ale_seen <= 1'b0;
      synced <= 1'b0;
      phase <= PHASE_0;
    end else begin
      if (ale_req_i && !hold_active) begin
        ale_seen <= 1'b1;
      end
      if (first_align) begin
        synced <= 1'b1;
        phase <= PHASE_0;
      end else if (synced && bclk_edge) begin
        phase <= phase + 2'h1;  // Kept through stop mode
      end
    end
  end

  // ****************************************
  // Speaker line handling
  // ****************************************
  logic spk_p0;              // Level sampled opening phase 0
  logic spk_p2;              // Level sampled opening phase 2
  wire open_p0 = first_align | (synced & bclk_rise & (phase == PHASE_3));
  wire open_p2 = synced & bclk_rise & (phase == PHASE_1);
  wire open_p3 = synced & bclk_fall & (phase == PHASE_2);
  pin_drive_type next_spk;

  // Drive decision for the next cycle
  always_comb begin
    next_spk = speaker_line_o;
    if (stop_mode_i) begin
      next_spk = '{out: 1'b0, oe: 1'b1};
    end else if (!synced) begin
      next_spk = '{out: 1'b0, oe: 1'b0};
    end else if (open_p0 || open_p2) begin
      next_spk.oe = 1'b0;
    end else if (open_p3) begin
      next_spk = '{out: spk_p2, oe: 1'b1};
    end
  end

  // Samples and registered pin drive
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      spk_p0 <= 1'b0;
      spk_p2 <= 1'b0;
      speaker_line_o <= '{out: 1'b0, oe: 1'b0};
    end else begin
      if (open_p0) begin
        spk_p0 <= spk_level;
      end
      if (open_p2) begin
        spk_p2 <= spk_level;
      end
      speaker_line_o <= next_spk;
    end
  end

  // ****************************************
  // Data bus idle
  // ****************************************
  assign sd_oe_o = cycle_active_i & sd_drive_i;

  // ****************************************
  // Backoff and DMA request inhibit
  // ****************************************
  logic drq_block;           // Backoff pending or in service
  wire backoff_seen = sel_low & ~ale_o;

  // Set wins over clear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      drq_block <= 1'b0;
      drq_o <= DRQ_NONE;
    end else begin
      drq_block <= backoff_seen | (drq_block & ~driveback_done_i);
      drq_o <= (backoff_seen | drq_block) ? DRQ_NONE : drq_i;
    end
  end

  assign backoff_grant_o = drq_block & bus_idle_i;

  // ****************************************
  // Clock halt permission
  // ****************************************
  logic stop_armed;          // Stop broadcast issued
  logic counting;            // Counting after strobe release
  logic cmd_last;            // Strobe state last cycle
  logic [2:0] halt_cnt;      // Rising edges still to wait
  wire cmd_release = cmd_last & ~cmd_active_i;

  // Arm, count rising edges, then hold the halt request
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      stop_armed <= 1'b0;
      counting <= 1'b0;
      cmd_last <= 1'b0;
      halt_cnt <= HALT_CNT_RST;
      clk_halt_o <= 1'b0;
    end else begin
      cmd_last <= cmd_active_i;
      if (!stop_mode_i && !stop_bcast_i) begin
        stop_armed <= 1'b0;
        counting <= 1'b0;
        clk_halt_o <= 1'b0;
      end else begin
        if (stop_bcast_i) begin
          stop_armed <= 1'b1;
        end
        if (stop_armed && cmd_release) begin
          counting <= 1'b1;
          halt_cnt <= clk_count_i;
        end else if (counting && bclk_rise) begin
          halt_cnt <= halt_cnt - 3'h1;
          if (halt_cnt <= 3'h1) begin
            counting <= 1'b0;
            clk_halt_o <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  chk_phase_align: assert property (first_align |=> synced && phase == PHASE_0)
    else $error("phase not aligned on first rise after ALE");
  chk_release_p0: assert property (open_p0 && !stop_mode_i |=> !speaker_line_o.oe)
    else $error("speaker still driven in phase 0");
  chk_release_p2: assert property (open_p2 && !stop_mode_i |=> !speaker_line_o.oe)
    else $error("speaker driven in phase 2");
  chk_drive_p3: assert property (open_p3 && !stop_mode_i
      |=> speaker_line_o.oe && speaker_line_o.out == $past(spk_p2))
    else $error("phase 3 drive level wrong");
  chk_stop_low: assert property (stop_mode_i |=> speaker_line_o.oe && !speaker_line_o.out)
    else $error("speaker not low in stop mode");
  chk_sd_idle: assert property (!cycle_active_i |-> !sd_oe_o)
    else $error("data bus driven while idle");
  chk_drq_inhibit: assert property (backoff_seen |=> (drq_o == DRQ_NONE) [*2])
    else $error("DMA request passed during backoff");
  chk_halt_armed: assert property ($rose(clk_halt_o) |-> $past(stop_armed))
    else $error("clock halted without stop broadcast");
  chk_ale_5v: assert property ($fell(srst_i) && bus_5v |-> ale_o [*4] ##1 (ale_o == ale_req_i))
    else $error("ALE not held high after reset");
  chk_ale_33v: assert property ($fell(srst_i) && !bus_5v |-> !ale_o [*4])
    else $error("ALE not held low after reset");

  cov_phase3_drive: cover property (open_p3 ##1 speaker_line_o.oe);
  cov_backoff_grant: cover property (backoff_seen ##[1:20] backoff_grant_o);
  cov_clock_halt: cover property (stop_bcast_i ##[1:300] clk_halt_o);

endmodule : spk_host
`default_nettype wire

// ### tb/spk_slave_model.sv
/*
  Behavioural slave on the shared speaker line: phase tracking and toggle drive.
  Assumes raw bus clock and ALE pins; the bench resolves the line level.
*/
`timescale 1ns/1ps
`default_nettype none
module spk_slave_model (
  // Pins; no command strobe, so bus cycles are never answered
  input wire logic bus_clock_i,
  input wire logic ale_i,
  input wire logic rst_i,
  input wire logic speaker_line_i,
  // Local control
  input wire logic enable_i,
  input wire logic stop_active_i,
  input wire logic stop_ready_i,
  input wire logic audio_i,
  // Line drive
  output logic oe_o,
  output logic out_o
);
  logic aligned = 1'b0;  // Phase lock found
  logic [1:0] phase = 2'h3;  // Current phase
  logic spk_p0 = 1'b0;  // Line level taken in phase 0
  logic aud = 1'b0;  // Audio taken this phase 1
  logic aud_prev = 1'b0;  // Audio taken last phase 1
  // ****************************************
  // Phase tracking on both bus clock edges
  // ****************************************
  // Rising edges open phases 0 and 2, falling edges 1 and 3
  always @(posedge bus_clock_i or negedge bus_clock_i or posedge rst_i) begin
    if (rst_i) begin
      aligned <= 1'b0;
    end else if (bus_clock_i) begin
      if (aligned || ale_i) begin
        aligned <= 1'b1;
        phase <= (aligned && phase == 2'h1) ? 2'h2 : 2'h0;
        if (!(aligned && phase == 2'h1)) spk_p0 <= speaker_line_i;
      end
    end else if (aligned) begin
      phase <= phase + 2'h1;
      if (phase == 2'h0) begin
        aud_prev <= aud;
        aud <= audio_i;
      end
    end
  end
  // Drive only in phase 1, only on a change
  assign oe_o = enable_i && aligned && phase == 2'h1 && aud != aud_prev
    && !(stop_active_i && stop_ready_i);
  assign out_o = !spk_p0;
endmodule : spk_slave_model
`default_nettype wire

// ### tb/spk_host_tb_top.sv
/*
  Self-checking bench for the speaker host with one slave model.
  Assumes a 40 MHz core clock and a free bus clock of 200 ns.
*/
`timescale 1ns/1ps
`default_nettype none
module spk_host_tb_top;
  import spk_host_pkg::*;
  logic clock_i = 1'b0, srst_i = 1'b1, bclk = 1'b0, bclk_run = 1'b0;
  logic spk_level = 1'b0, sel_n = 1'b1, bus_5v = 1'b0, ale_req = 1'b0;
  logic cyc = 1'b0, sd_drv = 1'b0, done = 1'b0, idle = 1'b0, bcast = 1'b0;
  logic stopm = 1'b0, cmd = 1'b0, audio = 1'b0, slv_en = 1'b0, spk_exp = 1'b0;
  logic slv_oe, slv_out, ale, sd_oe, grant, halt;
  logic [7:0] drq_i = 8'h00;
  logic [7:0] drq_o;
  logic [2:0] cnt = 3'h2;
  pin_drive_type spk_drv;
  int bad_count = 0;
  int n_tests = 0;
  // ****************************************
  // Clocks and line
  // ****************************************
  initial forever #12.5 clock_i = ~clock_i;
  // Bus clock edges kept off core edges
  initial begin
    #7;
    forever begin
      #100;
      if (bclk_run) bclk = ~bclk;
    end
  end
  // Released line keeps its level on the R-C
  always @* begin
    if (spk_drv.oe) spk_level = spk_drv.out;
    else if (slv_oe) spk_level = slv_out;
  end
  spk_host spk_host_inst (.clock_i(clock_i), .srst_i(srst_i), .bus_clock_i(bclk),
    .speaker_line_i(spk_level), .select_backoff_line_n_i(sel_n),
    .speaker_line_o(spk_drv), .bus_5v_i(bus_5v), .ale_req_i(ale_req), .ale_o(ale),
    .cycle_active_i(cyc), .sd_drive_i(sd_drv), .sd_oe_o(sd_oe), .drq_i(drq_i),
    .drq_o(drq_o), .driveback_done_i(done), .bus_idle_i(idle),
    .backoff_grant_o(grant), .stop_bcast_i(bcast), .stop_mode_i(stopm),
    .cmd_active_i(cmd), .clk_count_i(cnt), .clk_halt_o(halt));
  spk_slave_model spk_slave_model_inst (.bus_clock_i(bclk), .ale_i(ale), .rst_i(srst_i),
    .speaker_line_i(spk_level), .enable_i(slv_en), .stop_active_i(stopm),
    .stop_ready_i(stopm), .audio_i(audio), .oe_o(slv_oe), .out_o(slv_out));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : wait_cyc
  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  // ****************************************
  // Scenarios
  // ****************************************
  // Voltage strap on ALE around reset
  task automatic reset_strap(input logic v5, input logic req);
    @(negedge clock_i);
    srst_i = 1'b1;
    bus_5v = v5;
    ale_req = req;
    wait_cyc(8);
    check("ale_in_reset", 8'(v5), 8'(ale));
    srst_i = 1'b0;
    wait_cyc(2);
    check("ale_hold", 8'(v5), 8'(ale));
    wait_cyc(5);
    check("ale_follow", 8'(req), 8'(ale));
    ale_req = 1'b0;
  endtask : reset_strap
  // Data bus enable only inside a cycle
  task automatic data_bus;
    sd_drv = 1'b1;
    wait_cyc(1);
    check("sd_idle", 8'h00, 8'(sd_oe));
    cyc = 1'b1;
    wait_cyc(1);
    check("sd_cycle", 8'h01, 8'(sd_oe));
    cyc = 1'b0;
  endtask : data_bus
  // DMA block, grant and release
  task automatic backoff;
    drq_i = 8'h5a;
    wait_cyc(3);
    check("drq_pass", 8'h5a, drq_o);
    sel_n = 1'b0;
    wait_cyc(5);
    check("drq_block", 8'h00, drq_o);
    check("grant_busy", 8'h00, 8'(grant));
    idle = 1'b1;
    wait_cyc(1);
    check("grant", 8'h01, 8'(grant));
    sel_n = 1'b1;
    idle = 1'b0;
    wait_cyc(5);
    check("drq_hold", 8'h00, drq_o);
    done = 1'b1;
    wait_cyc(1);
    done = 1'b0;
    wait_cyc(3);
    check("drq_back", 8'h5a, drq_o);
  endtask : backoff
  // Four frames, slave toggles in two of them
  task automatic speaker;
    slv_en = 1'b1;
    bclk_run = 1'b1;
    ale_req = 1'b1;
    @(posedge bclk);
    for (int k = 0; k < 4; k++) begin
      #20;
      if (k == 1 || k == 2) begin
        audio = ~audio;
        spk_exp = ~spk_exp;
      end
      @(negedge bclk);
      #50 check("spk_p1_oe", 8'h00, 8'(spk_drv.oe));
      @(posedge bclk);
      @(negedge bclk);
      @(posedge bclk);
      #50 check("spk_p0_oe", 8'h01, 8'(spk_drv.oe));
      check("spk_level", 8'(spk_exp), 8'(spk_drv.out));
    end
    wait_cyc(1);
    ale_req = 1'b0;
  endtask : speaker
  // Stop mode drive and clock halt permission
  task automatic halt_seq;
    cmd = 1'b1;
    wait_cyc(2);
    cmd = 1'b0;
    repeat (3) @(posedge bclk);
    wait_cyc(6);
    check("halt_nobcast", 8'h00, 8'(halt));
    stopm = 1'b1;
    wait_cyc(2);
    check("stop_oe", 8'h01, 8'(spk_drv.oe));
    check("stop_low", 8'h00, 8'(spk_drv.out));
    @(negedge bclk);
    wait_cyc(1);
    cmd = 1'b1;
    bcast = 1'b1;
    wait_cyc(1);
    bcast = 1'b0;
    cmd = 1'b0;
    @(posedge bclk);
    wait_cyc(6);
    check("halt_early", 8'h00, 8'(halt));
    @(posedge bclk);
    wait_cyc(6);
    check("halt_set", 8'h01, 8'(halt));
    stopm = 1'b0;
  endtask : halt_seq
  // Main sequence
  initial begin
    reset_strap(1'b0, 1'b1);
    reset_strap(1'b1, 1'b0);
    data_bus();
    backoff();
    speaker();
    halt_seq();
    stop_test();
  end
  // Watchdog against a hang
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
endmodule : spk_host_tb_top
`default_nettype wire
